/* File: isf_sequencer.v */
// in-system flash command sequencer with its register port and flash arrays
//
// What this block does
// - command 1011 returns company identity byte
// - command 0010 erases whole addressed page
// - command 0001 programs data byte
// - command 0000 reads byte into data register
// - two top command bits select destination
// - pages are 128 bytes, erase full page
// - configuration addresses 0-3 map bytes 0-3
// - command 1100 returns identity low/high byte
// - read result held in data register
// - no configuration read from application code
// - configuration fully accessible only from loader
// - new config live after soft reset, boot bit not soft
// - loader read-only from application unless update enabled
// - lock bit never blocks programming commands
// - each region may read itself
// - enable write needs AA then 55 unlock
// - go bit starts held command
// - oscillator runs only while enabled
// - stall cpu during operation, go reads zero
// - fault flag on illegal access, software clears
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "isf_map.vh"
module isf_sequencer #(
  parameter [7:0] COMPANY_ID = 8'h5a,   // arbitrary value
  parameter [15:0] DEVICE_ID = 16'h1234 // arbitrary value
) (
  input  wire       clk_sys,     // system clock
  input  wire       srst,        // sync reset, active high
  input  wire       clk_en,      // freezes all state when low; srst still resets
  input  wire       soft_reset,  // pulse: software reset request
  input  wire       run_in_ldr,  // cpu executes from loader flash
  input  wire [7:0] addr,        // register address
  input  wire [7:0] wdata,       // write data
  input  wire       wr,          // write strobe
  input  wire       rd,          // read strobe
  output reg  [7:0] rdata,       // read data, cycle after rd
  output reg        cpu_hold,    // stalls program counter
  output reg        rc_osc_on,   // internal oscillator enable
  output reg  [7:0] cfg0_live,   // active configuration byte 0
  output reg        boot_ldr     // active boot selection
);
  localparam ST_IDLE = 2'd0;
  localparam ST_BUSY = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [7:0]  app_mem [0:16383];
  reg [7:0]  ldr_mem [0:2047];
  reg [7:0]  cfg_mem [0:3];
  reg [7:0]  cmd_r;
  reg [7:0]  ahi_r;
  reg [7:0]  alo_r;
  reg [7:0]  data_r;
  reg        en_r;
  reg        loader_update_enable_r;
  reg        boot_wr_r = 1'b0;
  reg        fault_r;
  reg [1:0]  ta_r;
  reg [1:0]  st_r;
  reg [4:0]  cnt_r;
  reg        erase_r;
  reg [6:0]  pg_r;
  reg        ok_r;
  wire [15:0] tgt = {ahi_r, alo_r};
  wire [1:0]  dst = cmd_r[7:6];
  wire        oe  = cmd_r[5];
  wire        ce  = cmd_r[4];
  wire [3:0]  fc  = cmd_r[3:0];
  wire        unlocked = (ta_r == 2'd2);
  integer     i;

  // access check; the lock bit plays no part here
  reg legal;
  always @* begin
    legal = 1'b1;
    if (ce)
      legal = 1'b0;
    else if (fc == `ISF_FC_CID || fc == `ISF_FC_DID)
      legal = !oe;
    else if (fc == `ISF_FC_READ)
      case (dst)
        `ISF_DST_APP: legal = !oe && tgt < 16'h4000;
        `ISF_DST_LDR: legal = !oe && tgt < 16'h0800;
        `ISF_DST_CFG: legal = !oe && run_in_ldr && tgt < 16'h0004;
        default:      legal = 1'b0;
      endcase
    else if (fc == `ISF_FC_PROG || fc == `ISF_FC_ERASE)
      case (dst)
        `ISF_DST_APP: legal = oe && run_in_ldr && tgt < 16'h4000;
        `ISF_DST_LDR: legal = oe && !run_in_ldr && loader_update_enable_r && tgt < 16'h0800;
        `ISF_DST_CFG: legal = oe && run_in_ldr && tgt < 16'h0004;
        default:      legal = 1'b0;
      endcase
    else
      legal = 1'b0;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      cmd_r     <= `ISF_CMD_RST;
      ahi_r     <= 8'h00;
      alo_r     <= 8'h00;
      data_r    <= 8'h00;
      en_r      <= 1'b0;
      loader_update_enable_r    <= 1'b0;
      fault_r   <= 1'b0;
      ta_r      <= 2'd0;
      st_r      <= ST_IDLE;
      cnt_r     <= 5'd0;
      erase_r   <= 1'b0;
      pg_r      <= 7'd0;
      ok_r      <= 1'b0;
      rdata     <= 8'h00;
      cpu_hold  <= 1'b0;
      rc_osc_on <= 1'b0;
      cfg0_live <= 8'hff;
      // boot choice loads only at a hard reset, taken from the last write
      boot_ldr  <= boot_wr_r;
      for (i = 0; i < 4; i = i + 1)
        cfg_mem[i] <= 8'hff;
    end else if (clk_en) begin
      rdata <= 8'h00;
      // unlock window lasts only for the next access
      if (wr && addr == `ISF_OFS_TIMED)
        ta_r <= (wdata == `ISF_TA_KEY1) ? 2'd1 :
                ((ta_r == 2'd1 && wdata == `ISF_TA_KEY2) ? 2'd2 : 2'd0);
      else if (wr || rd)
        ta_r <= 2'd0;
      if (rd) begin
        case (addr)
          `ISF_OFS_CHIP_CTL: rdata <= {1'b0, fault_r, loader_update_enable_r, 3'b000, boot_ldr, en_r};
          `ISF_OFS_CMD:      rdata <= cmd_r;
          `ISF_OFS_ADDR_HI:  rdata <= ahi_r;
          `ISF_OFS_ADDR_LO:  rdata <= alo_r;
          `ISF_OFS_DATA:     rdata <= data_r;
          `ISF_OFS_TRIG:     rdata <= 8'h00;
          `ISF_OFS_STATUS:   rdata <= {6'd0, ok_r, cpu_hold};
          default:           rdata <= 8'h00;
        endcase
      end
      if (wr && st_r == ST_IDLE) begin
        case (addr)
          `ISF_OFS_CMD:     cmd_r <= wdata;
          `ISF_OFS_ADDR_HI: ahi_r <= wdata;
          `ISF_OFS_ADDR_LO: alo_r <= wdata;
          `ISF_OFS_DATA:    data_r <= wdata;
          `ISF_OFS_CHIP_CTL: begin
            loader_update_enable_r <= wdata[`ISF_BIT_LOADER_UPDATE_ENABLE];
            boot_wr_r <= wdata[`ISF_BIT_BOOT];
            if (!wdata[`ISF_BIT_FAULT])
              fault_r <= 1'b0;
            if (unlocked)
              en_r <= wdata[`ISF_BIT_EN];
          end
          `ISF_OFS_TRIG:
            if (unlocked && en_r && wdata[0]) begin
              st_r     <= ST_BUSY;
              cpu_hold <= 1'b1;
              ok_r     <= legal;
              if (!legal)
                fault_r <= 1'b1;
              erase_r  <= 1'b0;
              pg_r     <= 7'd0;
              cnt_r    <= (fc == `ISF_FC_ERASE) ? `ISF_ERASE_CYC : `ISF_PROG_CYC;
            end
          default: ;
        endcase
      end
      rc_osc_on <= en_r;
      case (st_r)
        ST_IDLE: ;
        ST_BUSY: begin
          if (cnt_r > 5'd1)
            cnt_r <= cnt_r - 5'd1;
          else if (!ok_r)
            st_r <= ST_DONE;
          else if (fc == `ISF_FC_ERASE && dst != `ISF_DST_CFG && !erase_r) begin
            erase_r <= 1'b1;
            pg_r    <= 7'd0;
          end else
            st_r <= ST_DONE;
          // page erase walks all 128 bytes of the addressed page
          if (erase_r) begin
            if (dst == `ISF_DST_APP)
              app_mem[{tgt[13:`ISF_PAGE_BITS], pg_r}] <= 8'hff;
            else
              ldr_mem[{tgt[10:`ISF_PAGE_BITS], pg_r}] <= 8'hff;
            pg_r <= pg_r + 7'd1;
            if (pg_r == 7'h7f) begin
              erase_r <= 1'b0;
              st_r    <= ST_DONE;
            end else
              st_r <= ST_BUSY;
          end
        end
        ST_DONE: begin
          st_r     <= ST_IDLE;
          cpu_hold <= 1'b0;
          if (ok_r) begin
            if (fc == `ISF_FC_CID)
              data_r <= COMPANY_ID;
            else if (fc == `ISF_FC_DID)
              data_r <= tgt[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
            else if (fc == `ISF_FC_READ)
              case (dst)
                `ISF_DST_APP: data_r <= app_mem[tgt[13:0]];
                `ISF_DST_LDR: data_r <= ldr_mem[tgt[10:0]];
                default:      data_r <= cfg_mem[tgt[1:0]];
              endcase
            else if (fc == `ISF_FC_PROG)
              case (dst)
                `ISF_DST_APP: app_mem[tgt[13:0]] <= data_r;
                `ISF_DST_LDR: ldr_mem[tgt[10:0]] <= data_r;
                default:      cfg_mem[tgt[1:0]] <= data_r;
              endcase
            else if (dst == `ISF_DST_CFG)
              for (i = 0; i < 4; i = i + 1)
                cfg_mem[i] <= 8'hff;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
      // config takes effect on a soft reset; boot choice waits for a hard one
      if (soft_reset)
        cfg0_live <= cfg_mem[0];
    end
  end
endmodule

/* File: isf_map.vh */
// register offsets, field positions, command codes and timing counts for the flash sequencer
`ifndef ISF_MAP_VH
`define ISF_MAP_VH
`define ISF_OFS_CHIP_CTL   8'h9f
`define ISF_OFS_CMD        8'haf
`define ISF_OFS_ADDR_HI    8'ha7
`define ISF_OFS_ADDR_LO    8'ha6
`define ISF_OFS_DATA       8'hae
`define ISF_OFS_TRIG       8'ha4
`define ISF_OFS_TIMED      8'hc7
`define ISF_OFS_STATUS     8'hc8
`define ISF_CMD_RST        8'h30
`define ISF_TA_KEY1        8'haa
`define ISF_TA_KEY2        8'h55
`define ISF_FC_READ        4'h0
`define ISF_FC_PROG        4'h1
`define ISF_FC_ERASE       4'h2
`define ISF_FC_CID         4'hb
`define ISF_FC_DID         4'hc
`define ISF_DST_APP        2'h0
`define ISF_DST_LDR        2'h1
`define ISF_DST_CFG        2'h3
`define ISF_BIT_EN         0
`define ISF_BIT_BOOT       1
`define ISF_BIT_LOADER_UPDATE_ENABLE       5
`define ISF_BIT_FAULT      6
`define ISF_PAGE_BITS      7
`define ISF_ERASE_CYC      5'h05
`define ISF_PROG_CYC       5'h03
`endif

/* File: isf_sequencer_properties.sv */
// port assertions for the flash sequencer
`timescale 1ns/1ps
`include "isf_map.vh"
module isf_props (
  input wire       clk_sys,    // clock
  input wire       srst,       // sync reset
  input wire       soft_reset, // soft reset pulse
  input wire [7:0] addr,       // address
  input wire [7:0] wdata,      // write data
  input wire       wr,         // write strobe
  input wire       rd,         // read strobe
  input wire [7:0] rdata,      // read data
  input wire       cpu_hold,   // stall
  input wire       rc_osc_on,  // oscillator
  input wire       boot_ldr    // boot select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  reg key_r;
  always @(posedge clk_sys) begin
    key_r <= !srst && wr && addr == `ISF_OFS_TIMED && wdata == `ISF_TA_KEY2;
  end
  sequence s_unlock;
    wr && addr == `ISF_OFS_TIMED && wdata == `ISF_TA_KEY1 ##1 key_r == 1'b0 && wr
    && addr == `ISF_OFS_TIMED && wdata == `ISF_TA_KEY2;
  endsequence
  sequence s_trig;
    wr && addr == `ISF_OFS_TRIG && wdata[0] && rc_osc_on && !cpu_hold;
  endsequence
  property p_go; s_unlock ##1 s_trig |=> cpu_hold; endproperty
  a_go: assert property (p_go) else $error("trigger did not start");
  property p_nogo; wr && addr == `ISF_OFS_TRIG && !cpu_hold && !rc_osc_on |=> !cpu_hold;
  endproperty
  a_nogo: assert property (p_nogo) else $error("trigger ran while disabled");
  property p_key; wr && addr == `ISF_OFS_TRIG && !cpu_hold && $past(wr)
    && $past(addr) != `ISF_OFS_TIMED |=> !cpu_hold; endproperty
  a_key: assert property (p_key) else $error("trigger ran without unlock");
  property p_osc; cpu_hold |-> rc_osc_on; endproperty
  a_osc: assert property (p_osc) else $error("busy without oscillator");
  property p_off; wr && key_r && addr == `ISF_OFS_CHIP_CTL && !wdata[0] && !cpu_hold
    |-> ##2 !rc_osc_on; endproperty
  a_off: assert property (p_off) else $error("oscillator kept running");
  property p_bound; $rose(cpu_hold) |-> ##[1:200] !cpu_hold; endproperty
  a_bound: assert property (p_bound) else $error("stall never ended");
  property p_min; $rose(cpu_hold) |-> cpu_hold [*3]; endproperty
  a_min: assert property (p_min) else $error("stall too short");
  property p_rdz; !rd |=> rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside read");
  property p_trg0; rd && addr == `ISF_OFS_TRIG |=> rdata == 8'h00; endproperty
  a_trg0: assert property (p_trg0) else $error("go bit read as one");
  property p_boot; soft_reset |=> $stable(boot_ldr); endproperty
  a_boot: assert property (p_boot) else $error("boot moved on soft reset");
endmodule
bind isf_sequencer isf_props chk_u (.clk_sys, .srst, .soft_reset, .addr, .wdata, .wr, .rd,
  .rdata, .cpu_hold, .rc_osc_on, .boot_ldr);

/* File: isf_cpu_model.sv */
// firmware model driving the register port
`timescale 1ns/1ps
`include "isf_map.vh"
module isf_cpu_model (
  input  wire       clk_sys,   // clock
  input  wire       cpu_hold,  // stall
  input  wire [7:0] rdata,     // read data
  output reg  [7:0] addr,      // address
  output reg  [7:0] wdata,     // write data
  output reg        wr,        // write strobe
  output reg        rd,        // read strobe
  output reg        run_in_ldr // running from loader
);
  integer n;
  initial begin
    {addr, wdata, wr, rd, run_in_ldr} = 19'h0;
  end
  // wr left high so back-to-back writes never double-assign it
  task put(input [7:0] a, input [7:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
    end
  endtask
  task get(input [7:0] a, output [7:0] v);
    begin
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      v = rdata;
    end
  endtask
  // no interrupt can split the key pair in this model
  task ta(input [7:0] a, input [7:0] v);
    begin
      put(`ISF_OFS_TIMED, `ISF_TA_KEY1);
      put(`ISF_OFS_TIMED, `ISF_TA_KEY2);
      put(a, v);
      wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task go;
    begin
      ta(`ISF_OFS_TRIG, 8'h01);
      n = 0;
      @(posedge clk_sys);
      while (cpu_hold && n < 300) begin
        @(posedge clk_sys);
        n = n + 1;
      end
    end
  endtask
endmodule

/* File: isf_sequencer_test.sv */
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
module isf_sequencer_test;
  localparam [7:0] CID = 8'h3c;   // arbitrary value
  localparam [15:0] DEVICE_IDENTITY = 16'h9e71; // arbitrary value
  reg        clk_sys = 0, srst = 1, soft_reset = 0;
  wire [7:0] addr, wdata, rdata, cfg0_live;
  wire       wr, rd, cpu_hold, rc_osc_on, boot_ldr, run_in_ldr;
  reg  [7:0] d;
  integer    err_total = 0, checked = 0;
  always #2 clk_sys = ~clk_sys;
  isf_sequencer #(.COMPANY_ID(CID), .DEVICE_ID(DEVICE_IDENTITY)) dut_u (.clk_sys, .srst, .clk_en(1'b1),
    .soft_reset, .run_in_ldr, .addr, .wdata, .wr, .rd, .rdata, .cpu_hold, .rc_osc_on,
    .cfg0_live, .boot_ldr);
  isf_cpu_model cpu_u (.clk_sys, .cpu_hold, .rdata, .addr, .wdata, .wr, .rd, .run_in_ldr);
  task chk(input [7:0] s, input [7:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  task op(input [7:0] c, input [15:0] a, input [7:0] v);
    begin
      cpu_u.put(8'haf, c);
      cpu_u.put(8'ha7, a[15:8]);
      cpu_u.put(8'ha6, a[7:0]);
      cpu_u.put(8'hae, v);
      cpu_u.go;
    end
  endtask
  task rdb(input [7:0] c, input [15:0] a, input [7:0] e);
    begin
      op(c, a, 8'h00);
      cpu_u.get(8'hae, d);
      chk(d, e);
    end
  endtask
  task fault;
    begin
      cpu_u.get(8'h9f, d);
      chk(d & 8'h40, 8'h40);
      cpu_u.ta(8'h9f, 8'h01);
    end
  endtask
  task summarize;
    begin
      if (err_total == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #40000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    cpu_u.run_in_ldr <= 1'b1;
    cpu_u.ta(8'h9f, 8'h01);
    rdb(8'h0b, 16'h0000, CID);
    rdb(8'h0c, 16'h0000, DEVICE_IDENTITY[7:0]);
    rdb(8'h0c, 16'h0001, DEVICE_IDENTITY[15:8]);
    op(8'h22, 16'h0100, 8'h00);
    op(8'h22, 16'h0180, 8'h00);
    op(8'h21, 16'h0100, 8'ha5);
    op(8'h21, 16'h017f, 8'h3c);
    op(8'h21, 16'h0180, 8'h5a);
    rdb(8'h00, 16'h0100, 8'ha5);
    op(8'h22, 16'h0100, 8'h00);
    rdb(8'h00, 16'h017f, 8'hff);
    rdb(8'h00, 16'h0180, 8'h5a);
    op(8'he2, 16'h0000, 8'h00);
    op(8'he1, 16'h0003, 8'h6b);
    op(8'he1, 16'h0000, 8'h7c);
    rdb(8'hc0, 16'h0003, 8'h6b);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(cfg0_live, 8'h7c);
    cpu_u.run_in_ldr <= 1'b0;
    rdb(8'h00, 16'h0180, 8'h5a);
    cpu_u.ta(8'h9f, 8'h21);
    op(8'h62, 16'h0000, 8'h00);
    op(8'h61, 16'h0010, 8'hc3);
    rdb(8'h40, 16'h0010, 8'hc3);
    cpu_u.ta(8'h9f, 8'h01);
    op(8'h61, 16'h0010, 8'h00);
    fault;
    rdb(8'h40, 16'h0010, 8'hc3);
    op(8'hc0, 16'h0003, 8'h00);
    fault;
    cpu_u.run_in_ldr <= 1'b1;
    rdb(8'h40, 16'h0010, 8'hc3);
    cpu_u.put(8'hc7, 8'haa);
    cpu_u.put(8'hc7, 8'h55);
    cpu_u.put(8'haf, 8'h30);
    cpu_u.put(8'ha4, 8'h01);
    cpu_u.get(8'ha4, d);
    chk({7'h0, cpu_hold}, 8'h00);
    cpu_u.ta(8'h9f, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, rc_osc_on}, 8'h00);
    cpu_u.ta(8'ha4, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, cpu_hold}, 8'h00);
    cpu_u.get(8'ha4, d);
    chk(d, 8'h00);
    summarize;
  end
endmodule
